//--- hw/eid_pkg.sv
// Constants for the external interrupt detect block
package eid_pkg;

  // ---------------------------------------------------------------
  // Register map (word indices, byte address is four times)
  // ---------------------------------------------------------------
  localparam logic [7:0] EXT_INT_CONTROL_OFS = 8'hC6;
  localparam logic [7:0] REQ_ENABLE_OFS      = 8'hC8;
  localparam logic [7:0] PENDING_OFS         = 8'hCC;
  localparam logic [7:0] ACK_OFS             = 8'hD0;
  localparam logic [7:0] PIN_STATE_OFS       = 8'hD4;
  localparam logic [7:0] TIMER_CONTROL_OFS   = 8'hD8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_REQ2_TYPE_POS = 0;
  localparam int CTL_REQ3_TYPE_POS = 1;
  localparam int CTL_EDGE_LSB      = 2;
  localparam int CTL_EDGE_MSB      = 6;
  localparam int ENA_GLOBAL_POS    = 7;
  localparam int TCR_REQ0_TYPE_POS = 0;
  localparam int TCR_REQ0_FLAG_POS = 1;
  localparam int TCR_REQ1_TYPE_POS = 2;
  localparam int TCR_REQ1_FLAG_POS = 3;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] EXT_INT_CONTROL_RST = 8'h00;
  localparam logic [7:0] REQ_ENABLE_RST      = 8'h00;
  localparam logic [3:0] TIMER_CONTROL_RST   = 4'h0;
  localparam int         NUM_EXT_REQ         = 7;
  localparam int         NUM_VECTORS         = 15;
  localparam int         OSC_PER_MCYCLE      = 12;

endpackage

//--- hw/eid_sampler.sv
// Once-per-machine-cycle pin sampler with previous-sample history
`timescale 1ns/1ps
module eid_sampler #(
  parameter int WIDTH  = 7,
  parameter int PERIOD = 12
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] cur_r,
  output logic      [WIDTH-1:0] prev_r,
  output logic                  tick_r
);

  initial begin
    if (PERIOD < 1 || PERIOD > 255 || WIDTH < 1) begin
      $error("eid_sampler: bad parameter");
    end
  end

  logic [7:0] cnt_r;

  // ---------------------------------------------------------------
  // Machine cycle divider
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= 8'h00;
      tick_r <= 1'b0;
    end else if (cnt_r == 8'(PERIOD - 1)) begin
      cnt_r  <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Sample history, idle high like a pulled-up request line
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_r  <= '1;
      prev_r <= '1;
    end else if (cnt_r == 8'(PERIOD - 1)) begin
      cur_r  <= pins;
      prev_r <= cur_r;
    end
  end

endmodule

//--- hw/eid_top.sv
// External interrupt detect block with AHB-Lite register access
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// What this block does
// RULE1: The device owns the seven external sources of its fifteen vectors.
// RULE2: A software write to any request flag acts just like the hardware setting or clearing it; the flags of requests zero and one ignore writes at type 0.
// RULE3: Requests zero and one detect a low level at type 0 and a falling edge at type 1.
// RULE4: Requests two and three detect a falling edge at type 0 and a rising edge at type 1.
// RULE5: Requests four to six detect rising edges only.
// RULE6: The control register holds reserved bit 7, edge flags six to two, then types three and two.
// RULE7: A configured transition on pins two to six sets the matching edge flag.
// RULE8: Reset clears every implemented control register bit.
// RULE9: Edge flags clear on vectoring, while level requests follow the pin.
// RULE10: Pins are sampled once per machine cycle and edges need one cycle at each level.
// RULE11: A level source holds its request until serviced and drops it before the routine ends.
// RULE12: A request reaches the processor only when its enable and the global enable are set.
module eid_top #(
  parameter int MCYCLE_CLKS = eid_pkg::OSC_PER_MCYCLE
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_request_zero_n,
  input  wire logic        ext_request_one_n,
  input  wire logic        ext_request_two,
  input  wire logic        ext_request_three,
  input  wire logic        ext_request_four,
  input  wire logic        ext_request_five,
  input  wire logic        ext_request_six,
  input  wire logic        vector_ack,
  input  wire logic [2:0]  vector_id,
  output logic      [6:0]  irq_request
);

  localparam int N = eid_pkg::NUM_EXT_REQ;                        // see RULE1

  initial begin
    if (MCYCLE_CLKS < 1 || MCYCLE_CLKS > 255) begin
      $error("eid_top: MCYCLE_CLKS out of range");
    end
    if (N != 7 || eid_pkg::NUM_VECTORS < N) begin
      $error("eid_top: request count does not fit the ports");
    end
    if (eid_pkg::CTL_EDGE_MSB - eid_pkg::CTL_EDGE_LSB + 1 != N - 2) begin
      $error("eid_top: edge flag field does not fit the requests");
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [6:0]  ctl_r;
  logic [3:0]  tcr_r;
  logic [7:0]  ena_r;
  logic        ph_wr_r;
  logic [7:0]  ph_addr_r;
  logic [N-1:0] cur;
  logic [N-1:0] prev;
  logic        tick;
  logic [N-1:0] pin_vec;
  logic [N-1:0] pend;
  logic [N-1:0] det;
  logic [N-1:0] ack_vec;
  logic [N-1:0] vec_1h;
  logic [N-1:0] irq_nxt;
  logic        rd_take;
  logic        wr_ctl;
  logic        wr_tcr;
  logic        wr_ena;
  logic        wr_ack;
  logic [N-1:0] wr_ack_mask;
  logic [7:0]  rd_nxt;

  // ---------------------------------------------------------------
  // Request pins, zero in the lowest bit
  // ---------------------------------------------------------------
  assign pin_vec = {ext_request_six, ext_request_five, ext_request_four,
                    ext_request_three, ext_request_two,
                    ext_request_one_n, ext_request_zero_n};

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  eid_sampler #(
    .WIDTH  (N),
    .PERIOD (MCYCLE_CLKS)
  ) u_sampler (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (pin_vec),
    .cur_r   (cur),
    .prev_r  (prev),
    .tick_r  (tick)
  );

  // ---------------------------------------------------------------
  // Edge decode
  // ---------------------------------------------------------------
  function automatic logic fell(input logic p, input logic c);
    return p & ~c;
  endfunction

  function automatic logic rose(input logic p, input logic c);
    return ~p & c;
  endfunction

  // Type 1 picks the rising edge, type 0 the falling one
  function automatic logic edge_sel(input logic ty, input logic p, input logic c);
    return ty ? rose(p, c) : fell(p, c);
  endfunction

  always_comb begin
    det    = '0;
    det[0] = fell(prev[0], cur[0]);                               // see RULE3
    det[1] = fell(prev[1], cur[1]);                               // see RULE3
    det[2] = edge_sel(ctl_r[eid_pkg::CTL_REQ2_TYPE_POS], prev[2], cur[2]); // see RULE4
    det[3] = edge_sel(ctl_r[eid_pkg::CTL_REQ3_TYPE_POS], prev[3], cur[3]); // see RULE4
    for (int i = 4; i < N; i++) begin
      det[i] = rose(prev[i], cur[i]);                             // see RULE5
    end
    det = det & {N{tick}};                                        // see RULE10
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
    end else if (hready) begin
      ph_wr_r <= hsel & htrans[1] & hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_addr_r <= 8'h00;
    end else if (hready) begin
      ph_addr_r <= haddr[9:2];
    end
  end

  // Data-phase write aimed at one register word
  function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
                                  input logic [7:0] ofs);
    return wr && (idx == ofs);
  endfunction

  assign wr_ctl = wr_hit(ph_wr_r, ph_addr_r, eid_pkg::EXT_INT_CONTROL_OFS);
  assign wr_tcr = wr_hit(ph_wr_r, ph_addr_r, eid_pkg::TIMER_CONTROL_OFS);
  assign wr_ena = wr_hit(ph_wr_r, ph_addr_r, eid_pkg::REQ_ENABLE_OFS);
  assign wr_ack = wr_hit(ph_wr_r, ph_addr_r, eid_pkg::ACK_OFS);
  assign wr_ack_mask = wr_ack ? hwdata[N-1:0] : '0;

  // ---------------------------------------------------------------
  // Flag clears from vectoring and from the clear register
  // ---------------------------------------------------------------
  always_comb begin
    vec_1h = '0;
    if (vector_ack && (int'(vector_id) < N)) begin
      vec_1h[vector_id] = 1'b1;                                   // see RULE9
    end
  end

  assign ack_vec = vec_1h | wr_ack_mask;                          // see RULE2

  // ---------------------------------------------------------------
  // Edge flags and types
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= eid_pkg::EXT_INT_CONTROL_RST[6:0];                 // see RULE8
    end else begin
      for (int i = 2; i < N; i++) begin
        if (det[i]) begin
          ctl_r[i] <= 1'b1;                                       // see RULE7
        end else if (wr_ctl) begin
          ctl_r[i] <= hwdata[i];                                  // see RULE2
        end else if (ack_vec[i]) begin
          ctl_r[i] <= 1'b0;                                       // see RULE9
        end
      end
      if (wr_ctl) begin
        ctl_r[1:0] <= hwdata[1:0];                                // see RULE6
      end
    end
  end

  // ---------------------------------------------------------------
  // Requests zero and one: type bit and flag
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcr_r <= eid_pkg::TIMER_CONTROL_RST;
    end else begin
      if (wr_tcr) begin
        tcr_r[eid_pkg::TCR_REQ0_TYPE_POS] <= hwdata[eid_pkg::TCR_REQ0_TYPE_POS];
        tcr_r[eid_pkg::TCR_REQ1_TYPE_POS] <= hwdata[eid_pkg::TCR_REQ1_TYPE_POS];
      end
      for (int k = 0; k < 2; k++) begin
        if (!tcr_r[2*k]) begin
          tcr_r[2*k+1] <= ~cur[k];                                // see RULE3
        end else if (det[k]) begin
          tcr_r[2*k+1] <= 1'b1;
        end else if (wr_tcr) begin
          tcr_r[2*k+1] <= hwdata[2*k+1];                          // see RULE2
        end else if (ack_vec[k]) begin
          tcr_r[2*k+1] <= 1'b0;                                   // see RULE9
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Enables
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ena_r <= eid_pkg::REQ_ENABLE_RST;
    end else if (wr_ena) begin
      ena_r <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Pending flags and masked requests
  // ---------------------------------------------------------------
  assign pend = {ctl_r[6:2],
                 tcr_r[eid_pkg::TCR_REQ1_FLAG_POS],
                 tcr_r[eid_pkg::TCR_REQ0_FLAG_POS]};

  assign irq_nxt = pend & ena_r[N-1:0]
                 & {N{ena_r[eid_pkg::ENA_GLOBAL_POS]}};           // see RULE12

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_request <= '0;
    end else begin
      irq_request <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read data, registered at the address phase
  // ---------------------------------------------------------------
  always_comb begin
    unique case (haddr[9:2])
      eid_pkg::EXT_INT_CONTROL_OFS: rd_nxt = {1'b0, ctl_r};       // see RULE6
      eid_pkg::REQ_ENABLE_OFS:      rd_nxt = ena_r;
      eid_pkg::PENDING_OFS:         rd_nxt = {1'b0, pend};
      eid_pkg::PIN_STATE_OFS:       rd_nxt = {1'b0, cur};
      eid_pkg::TIMER_CONTROL_OFS:   rd_nxt = {4'h0, tcr_r};
      // Unmapped words read as zero
      default:                      rd_nxt = 8'h00;
    endcase
  end

  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= {24'h00_0000, rd_nxt};
    end
  end

  // ---------------------------------------------------------------
  // Bus response: no wait states, always OKAY
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

endmodule

//--- verif/eid_src_model.sv
// Behavioural model of the external request sources on the pins
`timescale 1ns/1ps
module eid_src_model #(
  parameter int HOLD = 4
) (
  input  wire logic       hclk,
  output logic      [6:0] pins
);
  // All sources idle high, so reset sees no edge
  initial pins = 7'h7F;

  // One level change, then held for at least one machine cycle
  task automatic drive(input int idx, input logic lv);
    @(posedge hclk);
    pins[idx] <= lv;
    repeat (HOLD) @(posedge hclk);
  endtask
endmodule

//--- verif/eid_monitor.sv
// Checker on the external interrupt detect ports
`timescale 1ns/1ps
module eid_monitor #(
  parameter int MCYCLE_CLKS = 2
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_request_zero_n,
  input wire logic        ext_request_four,
  input wire logic        vector_ack,
  input wire logic [2:0]  vector_id,
  input wire logic [6:0]  irq_request
);
  localparam int LAT = 2 * MCYCLE_CLKS + 2;
  logic       wr_q;
  logic [7:0] wa_q;
  logic [7:0] en_r;
  logic [3:0] tcr_r;
  // Shadow copies of the enable and timer-control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      wa_q  <= 8'h00;
      en_r  <= 8'h00;
      tcr_r <= 4'h0;
    end else begin
      wr_q <= htrans[1] && hwrite;
      wa_q <= haddr[9:2];
      if (wr_q && wa_q == eid_pkg::REQ_ENABLE_OFS) en_r <= hwdata[7:0];
      if (wr_q && wa_q == eid_pkg::TIMER_CONTROL_OFS) tcr_r <= hwdata[3:0];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_low0; (!ext_request_zero_n && !tcr_r[0] && en_r[0] && en_r[7]) [*6]; endsequence
  sequence s_high0; (ext_request_zero_n && !tcr_r[0]) [*6]; endsequence
  sequence s_fall4;
    (!irq_request[4] && $fell(ext_request_four)) ##1 (!ext_request_four && !htrans[1]) [*6];
  endsequence
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  property p_okay; $past(hresetn) |-> !hresp; endproperty
  property p_global; !$past(en_r[7]) |-> irq_request == 7'h00; endproperty
  property p_enable; (irq_request & ~$past(en_r[6:0])) == 7'h00; endproperty
  property p_lvl_hold; s_low0 |-> irq_request[0]; endproperty
  property p_lvl_drop; s_high0 |-> !irq_request[0]; endproperty
  property p_rise4; $rose(ext_request_four) && en_r[4] && en_r[7] |-> ##[1:LAT] irq_request[4];
  endproperty
  property p_fall4; s_fall4 |-> !irq_request[4]; endproperty
  property p_ack4; vector_ack && vector_id == 3'h4 |-> ##2 !irq_request[4]; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");
  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_global: assert property (p_global) else $error("request while all masked");
  a_enable: assert property (p_enable) else $error("request while masked");
  a_lvl_hold: assert property (p_lvl_hold) else $error("low level not seen");
  a_lvl_drop: assert property (p_lvl_drop) else $error("level flag stuck");
  a_rise4: assert property (p_rise4) else $error("rising edge missed");
  a_fall4: assert property (p_fall4) else $error("falling edge taken");
  a_ack4: assert property (p_ack4) else $error("vectoring left flag");
endmodule

bind eid_top eid_monitor #(.MCYCLE_CLKS(MCYCLE_CLKS)) mon_u (.hclk(hclk), .hresetn(hresetn),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp),
  .ext_request_zero_n(ext_request_zero_n), .ext_request_four(ext_request_four),
  .vector_ack(vector_ack), .vector_id(vector_id), .irq_request(irq_request));

//--- verif/test_external_interrupt_detect.sv
// Self-checking bench for the external interrupt detect block
`timescale 1ns/1ps
module test_external_interrupt_detect;
  localparam int         MC    = 2;
  localparam logic [7:0] A_CTL = eid_pkg::EXT_INT_CONTROL_OFS;
  localparam logic [7:0] A_TCR = eid_pkg::TIMER_CONTROL_OFS;
  localparam logic [7:0] A_EN  = eid_pkg::REQ_ENABLE_OFS;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite = 1'b0;
  logic        vector_ack = 1'b0;
  logic        hready, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  vector_id = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic [6:0]  pins, irq_request;
  logic [7:0]  ty, fl;
  int          failures = 0;
  int          check_count = 0;
  int          cyc = 0;

  assign hready = hreadyout;
  eid_top #(.MCYCLE_CLKS(MC)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_request_zero_n(pins[0]), .ext_request_one_n(pins[1]), .ext_request_two(pins[2]),
    .ext_request_three(pins[3]), .ext_request_four(pins[4]), .ext_request_five(pins[5]),
    .ext_request_six(pins[6]), .vector_ack(vector_ack), .vector_id(vector_id),
    .irq_request(irq_request));
  eid_src_model #(.HOLD(2 * MC)) src_u (.hclk(hclk), .pins(pins));
  initial forever #12.5 hclk = ~hclk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {22'h0, a, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg_%h", a), e, q);
  endtask

  task automatic irq_chk(input logic [6:0] e);
    repeat (2) @(posedge hclk);
    #1 check("irq_request", {25'h0, e}, {25'h0, irq_request});
  endtask

  task automatic ack(input int id);
    vector_id  <= id[2:0];
    vector_ack <= 1'b1;
    @(posedge hclk);
    vector_ack <= 1'b0;
    @(posedge hclk);
  endtask

  // Move one pin, wait out sampling latency, then read flags and requests
  task automatic step(input logic [7:0] a, input int k, input logic lv,
                      input logic [7:0] ev, input logic [6:0] ei);
    src_u.drive(k, lv);
    repeat (2 * MC + 4) @(posedge hclk);
    rd_chk(a, {24'h0, ev});
    irq_chk(ei);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(A_CTL, 32'h0);
    rd_chk(A_TCR, 32'h0);
    rd_chk(8'hF0, 32'h0);
    bus(1'b1, A_EN, 32'hFF);
    for (int k = 2; k < 7; k++) begin
      for (int t = 0; t < 2 - k / 4; t++) begin
        ty = (t == 1) ? 8'h1 << (k - 2) : 8'h0;
        fl = (k < 4 && t == 0) ? 8'h1 : 8'h0;
        bus(1'b1, A_CTL, {24'h0, ty});
        step(A_CTL, k, 1'b0, ty | (fl << k), 7'(fl << k));
        ack(k);
        step(A_CTL, k, 1'b1, ty | ((fl ^ 8'h1) << k), 7'((fl ^ 8'h1) << k));
        ack(k);
        rd_chk(A_CTL, {24'h0, ty});
      end
    end
    for (int j = 0; j < 2; j++) begin
      for (int t = 0; t < 2; t++) begin
        ty = 8'(t << (2 * j));
        fl = 8'h1 << (2 * j + 1);
        bus(1'b1, A_TCR, {24'h0, ty});
        step(A_TCR, j, 1'b0, ty | fl, 7'h1 << j);
        step(A_TCR, j, 1'b1, ty | (t == 1 ? fl : 8'h0), t == 1 ? 7'h1 << j : 7'h0);
        ack(j);
        rd_chk(A_TCR, {24'h0, ty});
      end
    end
    bus(1'b1, A_CTL, 32'hFF);
    rd_chk(A_CTL, 32'h7F);
    rd_chk(eid_pkg::PENDING_OFS, 32'h7C);
    rd_chk(eid_pkg::PIN_STATE_OFS, 32'h7F);
    irq_chk(7'h7C);
    bus(1'b1, A_EN, 32'hEF);
    irq_chk(7'h6C);
    bus(1'b1, A_EN, 32'h7F);
    irq_chk(7'h00);
    bus(1'b1, eid_pkg::ACK_OFS, 32'h7C);
    rd_chk(A_CTL, 32'h03);
    complete_run();
  end
endmodule
